// >>> hw/csf_params.svh
// Constants for the status word block: offsets, field positions, reset values.
// Operation
// - Three-bit priority field in bits seven-five
// - Effective level adds setup word fourth bit
// - Fourth priority bit set blocks user interrupts
// - No-nesting mode makes priority field read-only
// - Bit four shows repeat loop active
// - Bit three set on negative result
// - Bit two set on signed overflow
// - Zero flag set on zero result; non-zero result clears it
// - Bit zero set on carry out
// - Status write changes clip flags, combined clears
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CSF_OFF_STATUS 12'h000
`define CSF_OFF_SETUP 12'h004
`define CSF_OFF_IRQ1 12'h008
`define CSF_OFF_EXEC 12'h00C

// ****************************************************************
// Field positions
// ****************************************************************
`define CSF_PRI_HI 7
`define CSF_PRI_LO 5
`define CSF_RA_BIT 4
`define CSF_N_BIT 3
`define CSF_OV_BIT 2
`define CSF_Z_BIT 1
`define CSF_C_BIT 0
`define CSF_CLIP_A_BIT 13
`define CSF_CLIP_B_BIT 12
`define CSF_CLIP_ANY_BIT 11
`define CSF_SETUP_PRI3_BIT 3
`define CSF_NONEST_BIT 15
`define CSF_PRI_MAX 3'h7

// ****************************************************************
// Reset values
// ****************************************************************
`define CSF_STATUS_RST 16'h0000
`define CSF_PRI_RST 3'h0
`define CSF_SETUP_RST 16'h0000
`define CSF_IRQ1_RST 16'h0000

`endif

// >>> hw/csf_pkg.sv
// Types shared by the status word block.
package csf_pkg;
    // Which flags an operation touches
    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
        logic carry;
    } csf_affect_t;

    // Bus slave phases
    typedef enum logic [1:0] {
        CSF_IDLE,
        CSF_ACCESS
    } csf_bus_state_t;
endpackage : csf_pkg

// >>> hw/csf_flag_calc.sv
// Computes arithmetic result flags for a 16-bit operation result.
`include "csf_params.svh"
module csf_flag_calc (
    // Operation result
    input wire logic [15:0] result,
    input wire logic carry_out,
    input wire logic ovf_in,
    // Computed flags
    output logic neg,
    output logic ovf,
    output logic is_zero,
    output logic carry
);
    // Sign, zero and passthroughs
    always_comb begin
        neg = result[15];
        ovf = ovf_in;
        is_zero = (result == 16'h0000);
        carry = carry_out;
    end
endmodule : csf_flag_calc

// >>> hw/csf_priority.sv
// Forms the effective four-bit priority level and user interrupt block.
`include "csf_params.svh"
module csf_priority (
    // Priority sources
    input wire logic [2:0] pri_field,
    input wire logic pri_bit3,
    // Results
    output logic [3:0] eff_level,
    output logic user_blocked
);
    // Level seven or fourth bit blocks user interrupts
    always_comb begin
        eff_level = {pri_bit3, pri_field};
        user_blocked = pri_bit3 || (pri_field == `CSF_PRI_MAX);
    end
endmodule : csf_priority

// >>> hw/csf_status_top.sv
// Top of the status word block: APB slave, status word, setup and control words.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`include "csf_params.svh"
module csf_status_top (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Execution unit
    input wire logic op_valid,
    input wire logic [15:0] op_result,
    input wire logic op_carry,
    input wire logic op_ovf,
    input wire logic op_aff_neg,
    input wire logic op_aff_ovf,
    input wire logic op_aff_zero,
    input wire logic op_aff_carry,
    input wire logic repeat_busy,
    input wire logic clip_a_set,
    input wire logic clip_b_set,
    // Status to the core
    output logic [15:0] cpu_status_word,
    output logic [3:0] eff_level,
    output logic user_irq_blocked
);
    logic [15:0] status;
    logic [15:0] core_setup_word;
    logic [15:0] irq_setup_one;
    logic f_neg;
    logic f_ovf;
    logic f_zero;
    logic f_carry;
    logic [3:0] lvl;
    logic blk;
    csf_pkg::csf_affect_t aff;
    csf_pkg::csf_bus_state_t bus_state;
    logic wr_en;
    logic wr_lo;
    logic wr_hi;

    // ****************************************************************
    // Submodules
    // ****************************************************************
    csf_flag_calc u_calc (
        .result(op_result),
        .carry_out(op_carry),
        .ovf_in(op_ovf),
        .neg(f_neg),
        .ovf(f_ovf),
        .is_zero(f_zero),
        .carry(f_carry)
    );

    csf_priority u_pri (
        .pri_field(status[`CSF_PRI_HI:`CSF_PRI_LO]),
        .pri_bit3(core_setup_word[`CSF_SETUP_PRI3_BIT]),
        .eff_level(lvl),
        .user_blocked(blk)
    );

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Write takes effect only in the access phase, one cycle of wait state
    assign wr_en = psel && penable && pwrite && (bus_state == csf_pkg::CSF_ACCESS);
    assign wr_lo = wr_en && pstrb[0];
    assign wr_hi = wr_en && pstrb[1];

    // Pready rises one cycle into the access phase
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_state <= csf_pkg::CSF_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (psel && penable && !pready) begin
            bus_state <= csf_pkg::CSF_ACCESS;
            pready <= 1'b1;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (!pwrite) begin
                case (paddr)
                    `CSF_OFF_STATUS: prdata <= {16'h0000, status};
                    `CSF_OFF_SETUP: prdata <= {16'h0000, core_setup_word};
                    `CSF_OFF_IRQ1: prdata <= {16'h0000, irq_setup_one};
                    `CSF_OFF_EXEC: prdata <= {27'h0000000, blk, lvl};
                    default: pslverr <= 1'b1;
                endcase
            end else if (paddr != `CSF_OFF_STATUS && paddr != `CSF_OFF_SETUP && paddr != `CSF_OFF_IRQ1) begin
                pslverr <= 1'b1;
            end
        end else begin
            bus_state <= csf_pkg::CSF_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ****************************************************************
    // Setup and interrupt control words
    // ****************************************************************
    // Plain software words, byte-strobed
    always_ff @(posedge clk) begin
        if (srst) begin
            core_setup_word <= `CSF_SETUP_RST;
            irq_setup_one <= `CSF_IRQ1_RST;
        end else if (pready) begin
            if (wr_lo && paddr == `CSF_OFF_SETUP) core_setup_word[7:0] <= pwdata[7:0];
            if (wr_hi && paddr == `CSF_OFF_SETUP) core_setup_word[15:8] <= pwdata[15:8];
            if (wr_lo && paddr == `CSF_OFF_IRQ1) irq_setup_one[7:0] <= pwdata[7:0];
            if (wr_hi && paddr == `CSF_OFF_IRQ1) irq_setup_one[15:8] <= pwdata[15:8];
        end
    end

    // ****************************************************************
    // Status word
    // ****************************************************************
    assign aff = '{neg: op_aff_neg, ovf: op_aff_ovf, zero: op_aff_zero, carry: op_aff_carry};

    // Priority field: software write unless no-nesting mode locks it
    always_ff @(posedge clk) begin
        if (srst) begin
            status[`CSF_PRI_HI:`CSF_PRI_LO] <= `CSF_PRI_RST;
        end else if (pready && wr_lo && paddr == `CSF_OFF_STATUS && !irq_setup_one[`CSF_NONEST_BIT]) begin
            status[`CSF_PRI_HI:`CSF_PRI_LO] <= pwdata[`CSF_PRI_HI:`CSF_PRI_LO];
        end
    end

    // Arithmetic flags: execution unit wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            status[3:0] <= 4'h0;
        end else begin
            if (pready && wr_lo && paddr == `CSF_OFF_STATUS) status[3:0] <= pwdata[3:0];
            if (op_valid) begin
                if (aff.neg) status[`CSF_N_BIT] <= f_neg;
                if (aff.ovf) status[`CSF_OV_BIT] <= f_ovf;
                if (aff.zero && !f_zero) status[`CSF_Z_BIT] <= 1'b0;
                else if (aff.zero) status[`CSF_Z_BIT] <= 1'b1;
                if (aff.carry) status[`CSF_C_BIT] <= f_carry;
            end
        end
    end

    // Clip flags: hardware set wins over clear; writing the combined bit as zero clears both
    always_ff @(posedge clk) begin
        if (srst) begin
            status[`CSF_CLIP_A_BIT] <= 1'b0;
            status[`CSF_CLIP_B_BIT] <= 1'b0;
        end else begin
            if (pready && wr_hi && paddr == `CSF_OFF_STATUS) begin
                if (!pwdata[`CSF_CLIP_ANY_BIT]) begin
                    status[`CSF_CLIP_A_BIT] <= 1'b0;
                    status[`CSF_CLIP_B_BIT] <= 1'b0;
                end else begin
                    status[`CSF_CLIP_A_BIT] <= pwdata[`CSF_CLIP_A_BIT];
                    status[`CSF_CLIP_B_BIT] <= pwdata[`CSF_CLIP_B_BIT];
                end
            end
            if (clip_a_set) status[`CSF_CLIP_A_BIT] <= 1'b1;
            if (clip_b_set) status[`CSF_CLIP_B_BIT] <= 1'b1;
        end
    end

    // Unused bits held at zero; combined clip bit reads as OR
    always_ff @(posedge clk) begin
        if (srst) begin
            status[15:14] <= 2'h0;
            status[10:8] <= 3'h0;
            status[`CSF_RA_BIT] <= 1'b0;
            status[`CSF_CLIP_ANY_BIT] <= 1'b0;
        end else begin
            status[15:14] <= 2'h0;
            status[10:8] <= 3'h0;
            status[`CSF_RA_BIT] <= repeat_busy;
            status[`CSF_CLIP_ANY_BIT] <= status[`CSF_CLIP_A_BIT] | status[`CSF_CLIP_B_BIT];
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            cpu_status_word <= `CSF_STATUS_RST;
            eff_level <= 4'h0;
            user_irq_blocked <= 1'b0;
        end else begin
            cpu_status_word <= status;
            eff_level <= lvl;
            user_irq_blocked <= blk;
        end
    end
endmodule : csf_status_top

// >>> bench/csf_status_props.sv
// Port checker for the status word block.
module csf_status_props (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Bus handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Execution unit
    input wire logic op_valid,
    input wire logic [15:0] op_result,
    input wire logic op_carry,
    input wire logic op_ovf,
    input wire logic op_aff_neg,
    input wire logic op_aff_ovf,
    input wire logic op_aff_zero,
    input wire logic op_aff_carry,
    input wire logic repeat_busy,
    // Status outputs
    input wire logic [15:0] cpu_status_word,
    input wire logic [3:0] eff_level,
    input wire logic user_irq_blocked
);
    timeunit 1ns;
    timeprecision 1ps;
    // Single domain, so one clocking and one disable
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // ****
    // Flags show two edges after the operation
    // ****
    property p_neg;
        op_valid && op_aff_neg |-> ##2 cpu_status_word[3] == $past(op_result[15], 2);
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag wrong");
    property p_ovf;
        op_valid && op_aff_ovf |-> ##2 cpu_status_word[2] == $past(op_ovf, 2);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
    property p_zero;
        op_valid && op_aff_zero |-> ##2 cpu_status_word[1] == ($past(op_result, 2) == 16'h0000);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_carry;
        op_valid && op_aff_carry |-> ##2 cpu_status_word[0] == $past(op_carry, 2);
    endproperty
    a_carry: assert property (p_carry) else $error("carry flag wrong");
    // A bus write in the same edge may legally change the flag
    property p_keep;
        op_valid && !op_aff_carry && !(psel && pready) |-> ##2 cpu_status_word[0] == $past(cpu_status_word[0]);
    endproperty
    a_keep: assert property (p_keep) else $error("untouched flag changed");
    property p_ra;
        $stable(repeat_busy) [*3] |-> cpu_status_word[4] == repeat_busy;
    endproperty
    a_ra: assert property (p_ra) else $error("repeat flag wrong");
    // ****
    // Priority and bus answer
    // ****
    property p_pri;
        $stable(cpu_status_word[7:5]) [*3] |-> eff_level[2:0] == cpu_status_word[7:5];
    endproperty
    a_pri: assert property (p_pri) else $error("level low bits differ");
    property p_blk;
        $stable(eff_level) [*2] |-> user_irq_blocked == (eff_level[3] || eff_level[2:0] == 3'h7);
    endproperty
    a_blk: assert property (p_blk) else $error("block output wrong");
    property p_ready;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready timing wrong");
endmodule : csf_status_props

bind csf_status_top csf_status_props csf_status_props_inst (.clk, .srst, .psel, .penable, .pready, .op_valid,
    .op_result, .op_carry, .op_ovf, .op_aff_neg, .op_aff_ovf, .op_aff_zero, .op_aff_carry, .repeat_busy, .cpu_status_word,
    .eff_level, .user_irq_blocked);

// >>> bench/cpu_status_flags_tb_top.sv
// Self-checking bench for the status word block.
module cpu_status_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, eff_level;
    logic op_valid, op_carry, op_ovf, op_aff_neg, op_aff_ovf, op_aff_zero, op_aff_carry;
    logic repeat_busy, clip_a_set, clip_b_set, user_irq_blocked;
    logic [15:0] op_result, cpu_status_word, m;
    int num_errors, checked, seed, i;
    csf_status_top csf_status_top_inst (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .op_valid, .op_result, .op_carry, .op_ovf, .op_aff_neg, .op_aff_ovf,
        .op_aff_zero, .op_aff_carry, .repeat_busy, .clip_a_set, .clip_b_set, .cpu_status_word,
        .eff_level, .user_irq_blocked);
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    // Held until pready, then one idle cycle; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // Status output lags the internal word, so settle first
    task automatic cst();
        repeat (3) @(posedge clk);
        chk(cpu_status_word, m);
    endtask : cst
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        results();
    end
    // ****
    // Scenarios
    // ****
    initial begin
        seed = 32'h618E;
        {psel, penable, pwrite, op_valid, op_carry, op_ovf, op_aff_neg, op_aff_ovf} = 8'h00;
        {op_aff_zero, op_aff_carry, repeat_busy, clip_a_set, clip_b_set} = 5'h00;
        {paddr, pwdata, op_result, m} = '0;
        pstrb = 4'hF;
        srst = 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        cst();
        chk(eff_level, 32'h0);
        // Random operations, a zero result every fourth
        for (i = 0; i < 60; i++) begin
            {op_aff_neg, op_aff_ovf, op_aff_zero, op_aff_carry, op_carry, op_ovf} <= 6'($random(seed));
            op_result <= (i % 4 == 0) ? 16'h0000 : 16'($random(seed));
            op_valid <= 1'b1;
            @(posedge clk);
            op_valid <= 1'b0;
            if (op_aff_neg) m[3] = op_result[15];
            if (op_aff_ovf) m[2] = op_ovf;
            if (op_aff_zero) m[1] = (op_result == 16'h0000);
            if (op_aff_carry) m[0] = op_carry;
            cst();
        end
        // Every level with and without the fourth bit
        for (i = 0; i < 16; i++) begin
            apb(1'b1, 12'h004, {28'h0, i[3], 3'h0});
            m[7:5] = i[2:0];
            apb(1'b1, 12'h000, {16'h0, m});
            cst();
            chk({eff_level, user_irq_blocked}, {i[3:0], i[3] | (&i[2:0])});
        end
        // Priority frozen in no-nesting mode
        apb(1'b1, 12'h008, 32'h0000_8000);
        apb(1'b1, 12'h000, {16'h0, m ^ 16'h00E0});
        cst();
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b1, 12'h000, {16'h0, m ^ 16'h00E0});
        m = m ^ 16'h00E0;
        cst();
        // Repeat flag is hardware-owned; the write tries to clear it
        repeat_busy <= 1'b1;
        apb(1'b1, 12'h000, {16'h0, m});
        m[4] = 1'b1;
        cst();
        repeat_busy <= 1'b0;
        m[4] = 1'b0;
        cst();
        // Clip flags: hardware set, cleared by word write, set directly
        {clip_a_set, clip_b_set} <= 2'h3;
        @(posedge clk);
        {clip_a_set, clip_b_set} <= 2'h0;
        m[13:11] = 3'h7;
        cst();
        m[13:11] = 3'h0;
        apb(1'b1, 12'h000, {16'h0, m});
        cst();
        m[12:11] = 2'h3;
        apb(1'b1, 12'h000, {16'h0, m});
        cst();
        // Unmapped and read-only places
        apb(1'b0, 12'h010, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        chk(er, 1'b1);
        // Upper lane only: the fourth priority bit in the low byte must stay
        pstrb <= 4'h2;
        apb(1'b1, 12'h004, 32'h0);
        pstrb <= 4'hF;
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, {27'h0, 2'h3, m[7:5]});
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, {16'h0, m});
        results();
    end
endmodule : cpu_status_flags_tb_top
